/* bench/cll_host_model.sv */
/* I2C host model; the bench resolves open-drain SDA with a pull-up. */
`timescale 1ns/1ps
module cll_host_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    localparam int PH = 12;  // Clocks per SCL phase, above the slave minimum

    // Idle bus: both lines high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // All pin changes land on falling clock edges
    task automatic pause(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One bit: set in low phase, sampled late in high phase
    task automatic bit_x(input logic b, output logic r);
        sda_pull = !b;
        pause(PH);
        scl = 1'b1;
        pause(PH);
        r = sda_line;
        scl = 0;
        pause(2);
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(a, ack);
    endtask
    // Start or repeated start
    task automatic start_x;
        sda_pull = 1'b0;
        pause(PH);
        scl = 1'b1;
        pause(PH);
        sda_pull = 1'b1;
        pause(PH);
        scl = 1'b0;
        pause(2);
    endtask
    // Stop, leaving the bus idle
    task automatic stop_x;
        sda_pull = 1'b1;
        pause(PH);
        scl = 1'b1;
        pause(PH);
        sda_pull = 1'b0;
        pause(PH);
    endtask
    // Word write; acks holds the four acknowledge levels, low when taken
    task automatic wr_word(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, output logic [3:0] acks);
        logic [7:0] q;
        start_x();
        byte_x({a, 1'b0}, 1'b1, q, acks[3]);
        byte_x(p, 1'b1, q, acks[2]);
        byte_x(d[15:8], 1'b1, q, acks[1]);
        byte_x(d[7:0], 1'b1, q, acks[0]);
        stop_x();
    endtask
    // Word read with repeated start; last byte answered by NACK
    task automatic rd_word(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d, output logic [3:0] acks);
        logic ack;
        start_x();
        byte_x({a, 1'b0}, 1'b1, d[7:0], acks[3]);
        byte_x(p, 1'b1, d[7:0], acks[2]);
        start_x();
        byte_x({a, 1'b1}, 1'b1, d[7:0], acks[1]);
        byte_x(8'hff, 1'b0, d[15:8], ack);
        byte_x(8'hff, 1'b1, d[7:0], ack);
        acks[0] = 1'b0;
        stop_x();
    endtask
endmodule

/* bench/cll_regs_asserts.sv */
/* Checker on the bank's decoded outputs and pin timing; bound to its ports, one clock. */
`timescale 1ns/1ps
module cll_regs_asserts
    import cll_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        scl_in,
    input wire logic        sda_oe,
    input wire logic [15:0] current_limit_lock_config,
    input wire logic [15:0] drive_speed_protect_config,
    input wire logic [5:0]  overtemp_cap_dA,
    input wire logic        overtemp_cap_on,
    input wire logic [5:0]  soft_limit_dA,
    input wire logic        soft_limit_on,
    input wire logic [5:0]  hard_limit_dA,
    input wire logic [9:0]  pwm_period_cycles
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic [15:0] w = current_limit_lock_config;   // First word
    wire logic [15:0] v = drive_speed_protect_config;  // Second word

    // Decodes follow a word once it has settled for a cycle
    AST_OT_CAP: assert property ($stable(w) |-> overtemp_cap_dA == (w[15:14] == 2'h0 ? CUR_NONE :
        w[15:14] == 2'h1 ? OT_CAP_1A0 : w[15:14] == 2'h2 ? OT_CAP_1A6 : OT_CAP_2A0)) else $error("cap decode");
    AST_OT_ON: assert property ($stable(w) |-> overtemp_cap_on == (w[15:14] != 2'h0)) else $error("cap flag");
    AST_SOFT: assert property ($stable(w) |-> soft_limit_dA == {1'b0, w[7:4], 1'b0}) else $error("soft limit");
    AST_SOFT_ON: assert property ($stable(w) |-> soft_limit_on == (w[7:4] != 4'h0)) else $error("soft flag");
    AST_HARD_LO: assert property (!w[0] && $stable(w) |-> hard_limit_dA == (w[2:1] == 2'h0 ? HARD_R0_2A5 :
        w[2:1] == 2'h1 ? HARD_R0_1A9 : w[2:1] == 2'h2 ? HARD_R0_1A5 : HARD_R0_0A9)) else $error("hard range 0");
    AST_HARD_HI: assert property (w[0] && $stable(w) |->
        hard_limit_dA == ({3'h0, w[3:1]} + 6'h01) * HARD_R1_STEP) else $error("hard range 1");
    AST_PWM: assert property ($stable(v) |->
        pwm_period_cycles == (v[14] ? PWM_HIGH_PERIOD : PWM_LOW_PERIOD)) else $error("pwm period");
    // Words only move inside a write, in the SCL low phase after the last data bit
    AST_WORD_WRITE: assert property (!$stable({w, v}) |-> !scl_in [*3]) else $error("word moved");
    // SDA is only turned while SCL is low
    AST_SDA_TIMING: assert property (!$stable(sda_oe) |-> !scl_in [*4]) else $error("sda timing");
endmodule

bind cll_regs_top cll_regs_asserts chk (.clock, .nrst, .scl_in, .sda_oe, .current_limit_lock_config,
    .drive_speed_protect_config, .overtemp_cap_dA, .overtemp_cap_on, .soft_limit_dA, .soft_limit_on,
    .hard_limit_dA, .pwm_period_cycles);

/* bench/cll_regs_top_tb.sv */
/* Self-checking bench; the host model owns SCL and pulls SDA against a pull-up. */
`timescale 1ns/1ps
module cll_regs_top_tb
    import cll_pkg::*;
;
    logic             clock = 1'b0;  // 10 MHz system clock
    logic             nrst  = 1'b0;  // Low from time zero
    wire logic        scl, sda, sda_out, sda_oe, host_pull;
    wire logic [15:0] w1, w2, f2;    // Word ports; second word rebuilt from its fields
    wire logic [13:8] en;            // Lock detection enables
    wire logic [5:0]  hard;          // Hard lock limit
    wire logic [9:0]  period;        // Output PWM period
    int               num_errors = 0;
    int               compares   = 0;
    int               cycles     = 0;
    logic [15:0]      rd;
    logic [3:0]       acks;
    logic [15:0]      vals [12] = '{16'h0001, 16'h4113, 16'h8225, 16'hc447, 16'h08f9, 16'h10ab,
                                    16'h205d, 16'hff7f, 16'h3f80, 16'h7fc2, 16'hbfec, 16'h0006};
    logic [15:0]      vals2 [2] = '{16'h5a5a, 16'ha5a5};

    // Wired-AND SDA line with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & !host_pull;
    always #50 clock = ~clock;

    cll_regs_top uut (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .current_limit_lock_config(w1), .drive_speed_protect_config(w2), .overtemp_cap_dA(), .overtemp_cap_on(),
        .closed_loop_stall_enable(en[13]), .open_loop_stall_enable(en[12]), .missing_motor_enable(en[11]),
        .bemf_const_fault_enable(en[10]), .speed_fault_enable(en[9]), .lock_current_trip_enable(en[8]),
        .soft_limit_dA(), .soft_limit_on(), .hard_limit_dA(hard), .speed_input_select(f2[15]),
        .output_pwm_rate_select(f2[14]), .pwm_period_cycles(period), .bemf_const_threshold(f2[13:12]),
        .inductive_surge_enable(f2[11]), .mechanical_surge_enable(f2[10]), .mechanical_surge_mode(f2[9]),
        .position_detect_release_mode(f2[8]), .closed_loop_disable(f2[7]), .closed_loop_accel(f2[6:4]),
        .min_duty_limit(f2[3:2]), .phase_edge_rate(f2[1:0]));
    cll_host_model host (.clock(clock), .sda_line(sda), .scl(scl), .sda_pull(host_pull));

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic give_verdict;
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Reset for eight cycles, then settle the synchronisers
    task automatic do_reset;
        nrst = 1'b0;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        repeat (6) @(negedge clock);
    endtask
    // Register write and read at the default slave address
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.wr_word(I2C_ADDR_DEFAULT, p, d, acks);
        check("write acks", {12'h000, acks}, 16'h0000);
    endtask
    task automatic rdc(input logic [7:0] p, input logic [15:0] e);
        host.rd_word(I2C_ADDR_DEFAULT, p, rd, acks);
        check("read acks", {12'h000, acks}, 16'h0000);
        check("read data", rd, e);
    endtask

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        do_reset();
        check("word1 reset", w1, CFG_RESET);
        check("word2 reset", w2, CFG_RESET);
        check("hard reset", {10'h000, hard}, {10'h000, HARD_R0_2A5});
        check("period reset", {6'h00, period}, {6'h00, PWM_LOW_PERIOD});
        rdc(ADDR_CUR_LOCK, CFG_RESET);
        rdc(ADDR_DRIVE_PROT, CFG_RESET);
        // Every cap code, both ranges, every hard code
        foreach (vals[i]) begin
            wr(ADDR_CUR_LOCK, vals[i]);
            check("word1 port", w1, vals[i]);
            check("enables", {10'h000, en}, {10'h000, vals[i][13:8]});
            rdc(ADDR_CUR_LOCK, vals[i]);
        end
        foreach (vals2[i]) begin
            wr(ADDR_DRIVE_PROT, vals2[i]);
            check("word2 port", w2, vals2[i]);
            check("word2 fields", f2, vals2[i]);
            check("period", {6'h00, period}, {6'h00, vals2[i][14] ? PWM_HIGH_PERIOD : PWM_LOW_PERIOD});
            rdc(ADDR_DRIVE_PROT, vals2[i]);
        end
        // Foreign slave address is ignored
        host.wr_word(I2C_ADDR_DEFAULT ^ 7'h01, ADDR_CUR_LOCK, 16'hffff, acks);
        check("foreign acks", {12'h000, acks}, 16'h000f);
        check("word1 kept", w1, 16'h0006);
        // Unmapped pointer leaves both words alone
        wr(8'h96, 16'hffff);
        check("word1 kept", w1, 16'h0006);
        check("word2 kept", w2, 16'ha5a5);
        rdc(8'h96, 16'h0000);
        // Second reset clears both words
        do_reset();
        check("word1 reset", w1, CFG_RESET);
        check("word2 reset", w2, CFG_RESET);
        give_verdict();
    end
endmodule

/* rtl/cll_pkg.sv */
/* Constants of the configuration bank: addresses, fields, resets, current steps.
   Assumes a 10 MHz system clock. */
package cll_pkg;

    // System clock
    localparam int unsigned CLK_HZ            = 10_000_000;

    // Register word addresses (8-bit pointer space)
    localparam logic [7:0]  ADDR_CUR_LOCK     = 8'h94;
    localparam logic [7:0]  ADDR_DRIVE_PROT   = 8'h95;
    localparam logic [15:0] CFG_RESET         = 16'h0000;

    // First word field positions
    localparam int OT_CAP_HI   = 15;
    localparam int OT_CAP_LO   = 14;
    localparam int EN_CL_STALL = 13;
    localparam int EN_OL_STALL = 12;
    localparam int EN_NO_MOTOR = 11;
    localparam int EN_BEMF     = 10;
    localparam int EN_SPEED    = 9;
    localparam int EN_LOCK_CUR = 8;
    localparam int SOFT_HI     = 7;
    localparam int SOFT_LO     = 4;
    localparam int HARD_HI     = 3;
    localparam int HARD_LO     = 1;
    localparam int RANGE_SEL   = 0;

    // Second word field positions
    localparam int SPD_SEL     = 15;
    localparam int PWM_SEL     = 14;
    localparam int BEMF_HI     = 13;
    localparam int BEMF_LO     = 12;
    localparam int SURGE_IND   = 11;
    localparam int SURGE_MECH  = 10;
    localparam int SURGE_MODE  = 9;
    localparam int RELEASE_MD  = 8;
    localparam int CL_DIS      = 7;
    localparam int ACCEL_HI    = 6;
    localparam int ACCEL_LO    = 4;
    localparam int DUTY_HI     = 3;
    localparam int DUTY_LO     = 2;
    localparam int SLEW_HI     = 1;
    localparam int SLEW_LO     = 0;

    // Currents in units of 100 mA
    localparam logic [5:0]  CUR_NONE          = 6'h00;
    localparam logic [5:0]  OT_CAP_1A0        = 6'h0a;
    localparam logic [5:0]  OT_CAP_1A6        = 6'h10;
    localparam logic [5:0]  OT_CAP_2A0        = 6'h14;
    localparam logic [5:0]  SOFT_STEP         = 6'h02;
    localparam logic [5:0]  HARD_R0_2A5       = 6'h19;
    localparam logic [5:0]  HARD_R0_1A9       = 6'h13;
    localparam logic [5:0]  HARD_R0_1A5       = 6'h0f;
    localparam logic [5:0]  HARD_R0_0A9       = 6'h09;
    localparam logic [5:0]  HARD_R1_STEP      = 6'h04;

    // Output PWM period in system clocks at 25 kHz and 50 kHz
    localparam logic [9:0]  PWM_LOW_PERIOD    = 10'(CLK_HZ / 25_000);
    localparam logic [9:0]  PWM_HIGH_PERIOD   = 10'(CLK_HZ / 50_000);

    // Serial slave address, value is arbitrary
    localparam logic [6:0]  I2C_ADDR_DEFAULT  = 7'h52;

endpackage

/* rtl/cll_regs_top.sv */
/* Two 16-bit configuration words behind an I2C slave, with field decodes.
   Assumes open-drain SCL/SDA resolved outside and a master at 400 kHz or less. */
// Functional notes
// - First word at 0x94, read/write, resets zero
// - Bits 15:14 pick overtemperature current cap
// - Bit 13 enables closed-loop stall detection
// - Bit 12 enables open-loop stall detection
// - Bit 11 enables missing-motor fault detection
// - Bit 10 enables back-EMF constant fault detection
// - Bit 9 enables abnormal speed detection
// - Bit 8 enables lock current trip detection
// - Bits 7:4 soft limit, n times 0.2A
// - Range low: two-bit hard limit table
// - Range high: 0.4A steps to 3.2A
// - Second word at 0x95, fixed layout, resets zero
// - Bit 15 picks analog or PWM speed
// - Bit 14 picks 25 or 50 kHz
`timescale 1ns/1ps
module cll_regs_top
    import cll_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = I2C_ADDR_DEFAULT
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [15:0]     current_limit_lock_config,
    output logic [15:0]     drive_speed_protect_config,
    output logic [5:0]      overtemp_cap_dA,
    output logic            overtemp_cap_on,
    output logic            closed_loop_stall_enable,
    output logic            open_loop_stall_enable,
    output logic            missing_motor_enable,
    output logic            bemf_const_fault_enable,
    output logic            speed_fault_enable,
    output logic            lock_current_trip_enable,
    output logic [5:0]      soft_limit_dA,
    output logic            soft_limit_on,
    output logic [5:0]      hard_limit_dA,
    output logic            speed_input_select,
    output logic            output_pwm_rate_select,
    output logic [9:0]      pwm_period_cycles,
    output logic [1:0]      bemf_const_threshold,
    output logic            inductive_surge_enable,
    output logic            mechanical_surge_enable,
    output logic            mechanical_surge_mode,
    output logic            position_detect_release_mode,
    output logic            closed_loop_disable,
    output logic [2:0]      closed_loop_accel,
    output logic [1:0]      min_duty_limit,
    output logic [1:0]      phase_edge_rate
);

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } cll_state_t;

    cll_state_t  state_r;       // Slave state
    logic [1:0]  pin_s;         // Synchronised {scl, sda}
    logic        scl_d_r;       // Previous synchronised SCL
    logic        sda_d_r;       // Previous synchronised SDA
    logic        scl_s;         // Synchronised SCL
    logic        sda_s;         // Synchronised SDA
    logic        scl_rise;      // SCL rising edge
    logic        scl_fall;      // SCL falling edge
    logic        start_det;     // START or repeated START
    logic        stop_det;      // STOP
    logic [3:0]  bit_cnt_r;     // Bits seen in the current byte
    logic [7:0]  shift_r;       // Received byte
    logic [7:0]  ptr_r;         // Register word pointer
    logic        read_r;        // Transfer direction, 1 reads
    logic        half_r;        // 0 on high byte, 1 on low byte
    logic [7:0]  hi_byte_r;     // Held high byte of a write
    logic [15:0] tx_word_r;     // Word snapshot for a read
    logic [7:0]  tx_byte_r;     // Byte being shifted out
    logic        master_ack_r;  // Master acked the last read byte
    logic        wr_now;        // Word write strobe
    logic [15:0] wr_data;       // Word write data
    logic [15:0] cfg_a_r;       // First word
    logic [15:0] cfg_b_r;       // Second word
    logic [15:0] rd_word_w;     // Word at the read pointer

    // Read mux, unmapped words read as zero
    function automatic logic [15:0] read_word(input logic [7:0] addr, input logic [15:0] a, input logic [15:0] b);
        return (addr == ADDR_CUR_LOCK) ? a : (addr == ADDR_DRIVE_PROT) ? b : 16'h0000;
    endfunction

    // Overtemperature cap decode, zero means no cap
    function automatic logic [5:0] ot_cap(input logic [1:0] code);
        unique case (code)
            2'b00: return CUR_NONE;
            2'b01: return OT_CAP_1A0;
            2'b10: return OT_CAP_1A6;
            2'b11: return OT_CAP_2A0;
        endcase
    endfunction

    // Hard lock limit decode for both ranges
    function automatic logic [5:0] hard_lim(input logic [2:0] code, input logic range);
        logic [5:0] lin;
        lin = 6'({3'b000, code} + 6'h01) * HARD_R1_STEP;
        if (range) begin
            return lin;
        end
        unique case (code[1:0])
            2'b00: return HARD_R0_2A5;
            2'b01: return HARD_R0_1A9;
            2'b10: return HARD_R0_1A5;
            2'b11: return HARD_R0_0A9;
        endcase
    endfunction

    // Pins into the clock domain
    cll_sync #(
        .WIDTH (2),
        .INIT  (1'b1)
    ) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .d     ({scl_in, sda_in}),
        .q     (pin_s)
    );

    assign scl_s     = pin_s[1];
    assign sda_s     = pin_s[0];
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Word write happens on the last data bit of the low byte
    assign wr_now  = (state_r == ST_WDATA) && scl_fall && (bit_cnt_r == 4'd8) && half_r;
    assign wr_data = {hi_byte_r, shift_r};
    // After a full word has been read the next word is one past the pointer
    assign rd_word_w = read_word((state_r == ST_RACK) ? ptr_r + 8'h01 : ptr_r, cfg_a_r, cfg_b_r);

    // Edge history of the synchronised pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sda_out <= 1'b0;  // Open drain only ever pulls low
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            sda_out <= 1'b0;
        end
    end

    // Serial protocol engine
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r      <= ST_IDLE;
            bit_cnt_r    <= 4'd0;
            shift_r      <= 8'h00;
            ptr_r        <= 8'h00;
            read_r       <= 1'b0;
            half_r       <= 1'b0;
            hi_byte_r    <= 8'h00;
            tx_word_r    <= 16'h0000;
            tx_byte_r    <= 8'h00;
            master_ack_r <= 1'b0;
            sda_oe       <= 1'b0;
        end else if (start_det) begin
            // A START always restarts address reception
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'd0;
            half_r    <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else if (scl_rise) begin
            // Sample on the rising edge
            if (state_r == ST_RACK) begin
                master_ack_r <= ~sda_s;
            end else if (state_r == ST_ADDR || state_r == ST_PTR || state_r == ST_WDATA) begin
                shift_r   <= {shift_r[6:0], sda_s};
                bit_cnt_r <= bit_cnt_r + 4'd1;
            end else if (state_r == ST_RDATA) begin
                bit_cnt_r <= bit_cnt_r + 4'd1;
            end
        end else if (scl_fall) begin
            // Drive and move on at the falling edge
            unique case (state_r)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (bit_cnt_r == 4'd8) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            read_r  <= shift_r[0];
                            sda_oe  <= 1'b1;
                            state_r <= ST_ADDR_ACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt_r <= 4'd0;
                    if (read_r) begin
                        // Snapshot keeps both bytes of one word consistent
                        tx_word_r <= rd_word_w;
                        tx_byte_r <= {rd_word_w[14:8], 1'b0};
                        sda_oe    <= ~rd_word_w[15];
                        half_r    <= 1'b0;
                        state_r   <= ST_RDATA;
                    end else begin
                        sda_oe  <= 1'b0;
                        state_r <= ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (bit_cnt_r == 4'd8) begin
                        ptr_r   <= shift_r;
                        half_r  <= 1'b0;
                        sda_oe  <= 1'b1;
                        state_r <= ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    bit_cnt_r <= 4'd0;
                    sda_oe    <= 1'b0;
                    state_r   <= ST_WDATA;
                end
                ST_WDATA: begin
                    if (bit_cnt_r == 4'd8) begin
                        if (!half_r) begin
                            hi_byte_r <= shift_r;
                        end else begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                        half_r  <= ~half_r;
                        sda_oe  <= 1'b1;
                        state_r <= ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: begin
                    bit_cnt_r <= 4'd0;
                    sda_oe    <= 1'b0;
                    state_r   <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (bit_cnt_r == 4'd8) begin
                        // Release for the master's acknowledge
                        sda_oe  <= 1'b0;
                        state_r <= ST_RACK;
                    end else begin
                        sda_oe    <= ~tx_byte_r[7];
                        tx_byte_r <= tx_byte_r << 1;
                    end
                end
                ST_RACK: begin
                    bit_cnt_r <= 4'd0;
                    if (!master_ack_r) begin
                        state_r <= ST_IDLE;
                    end else if (!half_r) begin
                        // Low byte of the same word follows
                        half_r    <= 1'b1;
                        tx_byte_r <= {tx_word_r[6:0], 1'b0};
                        sda_oe    <= ~tx_word_r[7];
                        state_r   <= ST_RDATA;
                    end else begin
                        // Next word, pointer advances
                        ptr_r     <= ptr_r + 8'h01;
                        half_r    <= 1'b0;
                        tx_word_r <= rd_word_w;
                        tx_byte_r <= {rd_word_w[14:8], 1'b0};
                        sda_oe    <= ~rd_word_w[15];
                        state_r   <= ST_RDATA;
                    end
                end
            endcase
        end
    end

    // Configuration words, unmapped writes are dropped
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_a_r <= CFG_RESET;
            cfg_b_r <= CFG_RESET;
        end else if (wr_now) begin
            if (ptr_r == ADDR_CUR_LOCK) begin
                cfg_a_r <= wr_data;
            end
            if (ptr_r == ADDR_DRIVE_PROT) begin
                cfg_b_r <= wr_data;
            end
        end
    end

    // First word decode toward the current and lock logic
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            current_limit_lock_config <= CFG_RESET;
            overtemp_cap_dA           <= CUR_NONE;
            overtemp_cap_on           <= 1'b0;
            closed_loop_stall_enable  <= 1'b0;
            open_loop_stall_enable    <= 1'b0;
            missing_motor_enable      <= 1'b0;
            bemf_const_fault_enable   <= 1'b0;
            speed_fault_enable        <= 1'b0;
            lock_current_trip_enable  <= 1'b0;
            soft_limit_dA             <= CUR_NONE;
            soft_limit_on             <= 1'b0;
            hard_limit_dA             <= HARD_R0_2A5;
        end else begin
            current_limit_lock_config <= cfg_a_r;
            overtemp_cap_dA           <= ot_cap(cfg_a_r[OT_CAP_HI:OT_CAP_LO]);
            overtemp_cap_on           <= |cfg_a_r[OT_CAP_HI:OT_CAP_LO];
            closed_loop_stall_enable  <= cfg_a_r[EN_CL_STALL];
            open_loop_stall_enable    <= cfg_a_r[EN_OL_STALL];
            missing_motor_enable      <= cfg_a_r[EN_NO_MOTOR];
            bemf_const_fault_enable   <= cfg_a_r[EN_BEMF];
            speed_fault_enable        <= cfg_a_r[EN_SPEED];
            lock_current_trip_enable  <= cfg_a_r[EN_LOCK_CUR];
            soft_limit_dA             <= 6'({2'b00, cfg_a_r[SOFT_HI:SOFT_LO]} * SOFT_STEP);
            soft_limit_on             <= |cfg_a_r[SOFT_HI:SOFT_LO];
            hard_limit_dA             <= hard_lim(cfg_a_r[HARD_HI:HARD_LO], cfg_a_r[RANGE_SEL]);
        end
    end

    // Second word decode toward drive, speed and protection logic
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_speed_protect_config   <= CFG_RESET;
            speed_input_select           <= 1'b0;
            output_pwm_rate_select       <= 1'b0;
            pwm_period_cycles            <= PWM_LOW_PERIOD;
            bemf_const_threshold         <= 2'b00;
            inductive_surge_enable       <= 1'b0;
            mechanical_surge_enable      <= 1'b0;
            mechanical_surge_mode        <= 1'b0;
            position_detect_release_mode <= 1'b0;
            closed_loop_disable          <= 1'b0;
            closed_loop_accel            <= 3'b000;
            min_duty_limit               <= 2'b00;
            phase_edge_rate              <= 2'b00;
        end else begin
            drive_speed_protect_config   <= cfg_b_r;
            speed_input_select           <= cfg_b_r[SPD_SEL];
            output_pwm_rate_select       <= cfg_b_r[PWM_SEL];
            pwm_period_cycles            <= cfg_b_r[PWM_SEL] ? PWM_HIGH_PERIOD : PWM_LOW_PERIOD;
            bemf_const_threshold         <= cfg_b_r[BEMF_HI:BEMF_LO];
            inductive_surge_enable       <= cfg_b_r[SURGE_IND];
            mechanical_surge_enable      <= cfg_b_r[SURGE_MECH];
            mechanical_surge_mode        <= cfg_b_r[SURGE_MODE];
            position_detect_release_mode <= cfg_b_r[RELEASE_MD];
            closed_loop_disable          <= cfg_b_r[CL_DIS];
            closed_loop_accel            <= cfg_b_r[ACCEL_HI:ACCEL_LO];
            min_duty_limit               <= cfg_b_r[DUTY_HI:DUTY_LO];
            phase_edge_rate              <= cfg_b_r[SLEW_HI:SLEW_LO];
        end
    end

endmodule

/* rtl/cll_sync.sv */
/*
 * Two-flop synchroniser for a group of single-bit inputs.
 * Assumes each bit is a slow level from a pin; only the second stage is used.
 */
`timescale 1ns/1ps
module cll_sync #(
    parameter int    WIDTH = 2,
    parameter logic  INIT  = 1'b1
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;   // First stage, read only by q

    // Two stages toward the system clock
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= {WIDTH{INIT}};
            q      <= {WIDTH{INIT}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule
